// file: rstini_regs.svh
// Offsets, reset values, field positions and lookup entries of the block.
`ifndef RSTINI_REGS_SVH
`define RSTINI_REGS_SVH

// Entry layout: {offset index[8:0], reset value[7:0], bit mask[7:0], hold}.
`define RI_E_CORE_STATUS   {9'h003, 8'h18, 8'hFF, 1'b1}
`define RI_E_IRQ_CONTROL   {9'h00B, 8'h00, 8'hFF, 1'b0}
`define RI_E_PIRQ_FLAGS_1  {9'h00C, 8'h00, 8'hFF, 1'b0}
`define RI_E_PIRQ_FLAGS_2  {9'h00D, 8'h00, 8'h1F, 1'b0}
`define RI_E_ADC_CTL_0     {9'h01F, 8'h00, 8'h3F, 1'b0}
`define RI_E_T0_OPTION     {9'h081, 8'hFF, 8'hFF, 1'b0}
`define RI_E_PA_DIR        {9'h085, 8'hFF, 8'hFF, 1'b0}
`define RI_E_PB_DIR        {9'h086, 8'hFF, 8'hFF, 1'b0}
`define RI_E_PC_DIR        {9'h087, 8'hFF, 8'hFF, 1'b0}
`define RI_E_PD_DIR        {9'h088, 8'hFF, 8'hFF, 1'b0}
`define RI_E_PE_DIR        {9'h089, 8'h0F, 8'h0F, 1'b0}
`define RI_E_PIRQ_EN_1     {9'h08C, 8'h00, 8'hFF, 1'b0}
`define RI_E_PIRQ_EN_2     {9'h08D, 8'h00, 8'h1F, 1'b0}
`define RI_E_RESET_CAUSE   {9'h08E, 8'h00, 8'h03, 1'b1}
`define RI_E_T1_GATE_CTL   {9'h08F, 8'h00, 8'hFF, 1'b1}
`define RI_E_OSC_CTL       {9'h090, 8'h20, 8'h33, 1'b0}
`define RI_E_OSC_TUNE      {9'h091, 8'h00, 8'h3F, 1'b1}
`define RI_E_T2_PERIOD     {9'h092, 8'hFF, 8'hFF, 1'b0}
`define RI_E_SSP_ADDR      {9'h093, 8'h00, 8'hFF, 1'b0}
`define RI_E_SSP_MASK      {9'h093, 8'hFF, 8'hFF, 1'b0}
`define RI_E_SSP_STATE     {9'h094, 8'h00, 8'hFF, 1'b0}
`define RI_E_PB_PULLUP     {9'h095, 8'hFF, 8'hFF, 1'b0}
`define RI_E_PB_CHANGE     {9'h096, 8'h00, 8'hFF, 1'b0}
`define RI_E_T3_CTL        {9'h097, 8'h00, 8'hF5, 1'b0}
`define RI_E_USART_TX_CTL  {9'h098, 8'h02, 8'hF7, 1'b0}
`define RI_E_USART_BAUD    {9'h099, 8'h00, 8'hFF, 1'b0}
`define RI_E_T3_CNT_LO     {9'h09A, 8'h00, 8'hFF, 1'b1}
`define RI_E_T3_CNT_HI     {9'h09B, 8'h00, 8'hFF, 1'b1}
`define RI_E_ALT_PIN_FN    {9'h09C, 8'h00, 8'h03, 1'b0}
`define RI_E_FIXED_REF     {9'h09D, 8'h00, 8'hFF, 1'b0}
`define RI_E_ADC_CTL_1     {9'h09F, 8'h00, 8'h1F, 1'b0}
`define RI_E_TA_CTL        {9'h105, 8'h00, 8'hBF, 1'b0}
`define RI_E_CSB_CTL_0     {9'h106, 8'h00, 8'h3F, 1'b0}
`define RI_E_CSB_CTL_1     {9'h107, 8'h00, 8'h0F, 1'b0}
`define RI_E_CSA_CTL_0     {9'h108, 8'h00, 8'h3F, 1'b0}
`define RI_E_CSA_CTL_1     {9'h109, 8'h00, 8'h0F, 1'b0}
`define RI_E_PM_DATA_LO    {9'h10C, 8'h00, 8'hFF, 1'b1}
`define RI_E_PM_ADDR_LO    {9'h10D, 8'h00, 8'hFF, 1'b1}
`define RI_E_PM_DATA_HI    {9'h10E, 8'h00, 8'h3F, 1'b1}
`define RI_E_PM_ADDR_HI    {9'h10F, 8'h00, 8'h1F, 1'b1}
`define RI_E_TA_CNT        {9'h110, 8'h00, 8'hFF, 1'b0}
`define RI_E_TB_CTL        {9'h111, 8'h00, 8'hBF, 1'b0}
`define RI_E_TB_CNT        {9'h112, 8'h00, 8'hFF, 1'b0}
`define RI_E_DAC_CTL_0     {9'h113, 8'h00, 8'hEC, 1'b0}
`define RI_E_DAC_LEVEL     {9'h114, 8'h00, 8'h1F, 1'b0}
`define RI_E_PA_ANALOG     {9'h185, 8'hFF, 8'hFF, 1'b0}
`define RI_E_PB_ANALOG     {9'h186, 8'hFF, 8'hFF, 1'b0}
`define RI_E_PC_ANALOG     {9'h187, 8'hFF, 8'hFF, 1'b0}
`define RI_E_PD_ANALOG     {9'h188, 8'hFF, 8'hFF, 1'b0}
`define RI_E_PE_ANALOG     {9'h189, 8'h07, 8'h07, 1'b0}
`define RI_E_PM_ACCESS     {9'h18C, 8'h02, 8'h03, 1'b0}

// Block-local registers and table size.
`define RI_NREG            51
`define RI_IRQ_STATUS      9'h1F0
`define RI_IRQ_ENABLE      9'h1F1
`define RI_IRQ_CLEAR       9'h1F2
`define RI_BLOCK_CTL       9'h1F3

// Field positions and constants.
`define RI_STATUS_TMO      4
`define RI_STATUS_PWD      3
`define RI_INT_EN_BIT      7
`define RI_CAUSE_POR       1
`define RI_CAUSE_BRN       0
`define RI_BRN_CFG_OFF     2'h0
`define RI_IRQ_VECTOR      13'h0004
`define RI_NEVT            6

`endif

// file: rstini_pkg.sv
// Types shared by the reset initialisation block.
package rstini_pkg;

    // Reset class that is being applied in a cycle.
    typedef enum logic [2:0] {
        RSTINI_NONE,
        RSTINI_POWER,
        RSTINI_BROWN,
        RSTINI_EXTPIN,
        RSTINI_WDOG,
        RSTINI_WAKE_TO,
        RSTINI_WAKE_IRQ
    } rstini_class_t;

    // One entry of the initialisation table.
    typedef struct packed {
        logic [8:0] addr;
        logic [7:0] init;
        logic [7:0] mask;
        logic       hold;
    } rstini_entry_t;

endpackage

// file: rstini_core.sv
// Reset initialisation register bank with a classic Wishbone slave.
`timescale 1ns/1ns
`include "rstini_regs.svh"

// Operation
// (RULE1) Interrupt wake with global enable loads vector
// (RULE2) Interrupt wake sets at least one flag
// (RULE3) Brown-out clears flag bit 0, else holds
// (RULE4) Unimplemented bits always read as zero
// (RULE5) Pin and watchdog resets share one class
// (RULE6) Wake keeps contents except forced bits
// (RULE7) Timeout and powerdown flags follow reset cause
// (RULE8) Power-on overrides any other reset class
// (RULE9) Power-on clears flag bit 1; software sets
// (RULE10) Brown flag undefined after power-on, config gated
// (RULE11) Priority select: power-on, other, then hold
module rstini_core
    import rstini_pkg::*;
(
    input  wire logic          clk_i,          // Core clock, 100 MHz.
    input  wire logic          rst_i,          // Synchronous reset, high.
    input  wire logic          cyc_i,          // Wishbone cycle.
    input  wire logic          stb_i,          // Wishbone strobe.
    input  wire logic          we_i,           // Wishbone write enable.
    input  wire logic [11:0]   adr_i,          // Wishbone byte address.
    input  wire logic [3:0]    sel_i,          // Wishbone byte selects.
    input  wire logic [31:0]   dat_i,          // Wishbone write data.
    output logic      [31:0]   dat_o,          // Wishbone read data.
    output logic               ack_o,          // Wishbone acknowledge.
    input  wire logic          power_on_i,     // Power-on reset source.
    input  wire logic          brownout_i,     // Brown-out reset source.
    input  wire logic          ext_reset_pin_i, // External reset pin.
    input  wire logic          watchdog_i,     // Watchdog reset source.
    input  wire logic          wake_irq_i,     // Wake by interrupt.
    input  wire logic          wake_timeout_i, // Wake by time-out.
    input  wire logic [1:0]    brownout_detect_config_i, // Brown-out cfg.
    input  wire logic [23:0]   wake_flags_i,   // Wake source flags.
    input  wire logic [1:0]    osc_state_i,    // Oscillator state bits.
    output logic               pc_load_o,      // Load program counter.
    output logic      [12:0]   pc_vector_o,    // Program counter value.
    output rstini_class_t      reset_class_o,  // Last applied class.
    output logic               irq_o           // Level interrupt.
);

    localparam int NREG = `RI_NREG;
    localparam int IX_STATUS = 0;
    localparam int IX_INTCTL = 1;
    localparam int IX_FLAGS1 = 2;
    localparam int IX_FLAGS2 = 3;
    localparam int IX_PA_DIR = 6;
    localparam int IX_CAUSE  = 13;
    localparam int IX_OSC    = 15;
    localparam int IX_SSPADR = 18;
    localparam int IX_SSMASK = 19;
    localparam int IX_FVR    = 29;

    // Initialisation table, one entry per register, in index order.
    localparam rstini_entry_t TABLE [NREG] = '{
        `RI_E_CORE_STATUS, `RI_E_IRQ_CONTROL, `RI_E_PIRQ_FLAGS_1,
        `RI_E_PIRQ_FLAGS_2, `RI_E_ADC_CTL_0, `RI_E_T0_OPTION,
        `RI_E_PA_DIR, `RI_E_PB_DIR, `RI_E_PC_DIR, `RI_E_PD_DIR,
        `RI_E_PE_DIR, `RI_E_PIRQ_EN_1, `RI_E_PIRQ_EN_2,
        `RI_E_RESET_CAUSE, `RI_E_T1_GATE_CTL, `RI_E_OSC_CTL,
        `RI_E_OSC_TUNE, `RI_E_T2_PERIOD, `RI_E_SSP_ADDR,
        `RI_E_SSP_MASK, `RI_E_SSP_STATE, `RI_E_PB_PULLUP,
        `RI_E_PB_CHANGE, `RI_E_T3_CTL, `RI_E_USART_TX_CTL,
        `RI_E_USART_BAUD, `RI_E_T3_CNT_LO, `RI_E_T3_CNT_HI,
        `RI_E_ALT_PIN_FN, `RI_E_FIXED_REF, `RI_E_ADC_CTL_1,
        `RI_E_TA_CTL, `RI_E_CSB_CTL_0, `RI_E_CSB_CTL_1,
        `RI_E_CSA_CTL_0, `RI_E_CSA_CTL_1, `RI_E_PM_DATA_LO,
        `RI_E_PM_ADDR_LO, `RI_E_PM_DATA_HI, `RI_E_PM_ADDR_HI,
        `RI_E_TA_CNT, `RI_E_TB_CTL, `RI_E_TB_CNT,
        `RI_E_DAC_CTL_0, `RI_E_DAC_LEVEL, `RI_E_PA_ANALOG,
        `RI_E_PB_ANALOG, `RI_E_PC_ANALOG, `RI_E_PD_ANALOG,
        `RI_E_PE_ANALOG, `RI_E_PM_ACCESS
    };

    // Returns the table index for an offset, or NREG on a miss.
    function automatic int find_index(input logic [8:0] off);
        int r;
        r = NREG;
        for (int k = NREG - 1; k >= 0; k--)
        begin
            if (TABLE[k].addr == off)
                r = k;
        end
        return r;
    endfunction

    logic [7:0]              regs_reg [NREG];
    logic [`RI_NEVT-1:0]     sync1_reg;
    logic [`RI_NEVT-1:0]     sync2_reg;
    logic [`RI_NEVT-1:0]     sync3_reg;
    logic [`RI_NEVT-1:0]     filt_reg;
    logic [`RI_NEVT-1:0]     filt_next;
    logic [`RI_NEVT-1:0]     evt;
    logic [`RI_NEVT-1:0]     irq_status_reg;
    logic [`RI_NEVT-1:0]     irq_enable_reg;
    logic                    ssp_mask_sel_reg;
    logic                    brown_ok;
    logic                    wake_ok;
    rstini_class_t           cls;
    logic [8:0]              off;
    int                      idx;
    logic                    req;
    logic                    wr_commit;
    logic [`RI_NEVT-1:0]     irq_clr;

    // Three-stage synchronisers; a change counts when stages two and three
    // agree, so a single-cycle glitch on a source pin is ignored.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sync3_reg <= '0;
            filt_reg  <= '0;
        end
        else
        begin
            sync1_reg <= {wake_timeout_i, wake_irq_i, watchdog_i,
                          ext_reset_pin_i, brownout_i, power_on_i};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            filt_reg  <= filt_next;
        end
    end

    // Filtered level and rising-edge events.
    assign filt_next = (sync2_reg & sync3_reg) |
                       (filt_reg & (sync2_reg ^ sync3_reg));
    assign evt = filt_next & ~filt_reg;

    // Brown-out events count only while detection is enabled.
    assign brown_ok = evt[1] &&
                      (brownout_detect_config_i != `RI_BRN_CFG_OFF); // RULE10
    // An interrupt wake needs an implemented flag to record its source.
    assign wake_ok = evt[4] && (|wake_flags_i[20:0]); // RULE2

    // Class selection by priority; power-on beats every other class.
    always_comb
    begin
        cls = RSTINI_NONE;
        if (evt[0])
            cls = RSTINI_POWER; // RULE8 RULE11
        else if (brown_ok)
            cls = RSTINI_BROWN;
        else if (evt[2])
            cls = RSTINI_EXTPIN; // RULE5
        else if (evt[3])
            cls = RSTINI_WDOG; // RULE5
        else if (evt[5])
            cls = RSTINI_WAKE_TO;
        else if (wake_ok)
            cls = RSTINI_WAKE_IRQ;
    end

    // Bus decode; the shared serial address offset is steered by a mode bit.
    assign off = adr_i[10:2];
    assign req = cyc_i && stb_i;
    always_comb
    begin
        idx = find_index(off);
        if (adr_i[11])
            idx = NREG;
        if (idx == IX_SSPADR && ssp_mask_sel_reg)
            idx = IX_SSMASK;
    end
    assign wr_commit = req && we_i && ack_o && sel_i[0];

    // Acknowledge one cycle after the request, and drop it after one cycle.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_o <= 1'b0;
        else
            ack_o <= req && !ack_o;
    end

    // Read data; unmapped offsets and write-only clears read as zero.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            dat_o <= '0;
        else if (req && !ack_o)
        begin
            dat_o <= '0;
            if (idx < NREG)
                dat_o[7:0] <= regs_reg[idx] & TABLE[idx].mask; // RULE4
            else if (off == `RI_IRQ_STATUS && !adr_i[11])
                dat_o[`RI_NEVT-1:0] <= irq_status_reg;
            else if (off == `RI_IRQ_ENABLE && !adr_i[11])
                dat_o[`RI_NEVT-1:0] <= irq_enable_reg;
            else if (off == `RI_BLOCK_CTL && !adr_i[11])
                dat_o[0] <= ssp_mask_sel_reg;
        end
    end

    // Register file.  Reset classes outrank bus writes in the same cycle,
    // which loses that write but never leaves a half-initialised bank.
    always_ff @(posedge clk_i)
    begin
        for (int i = 0; i < NREG; i++)
        begin
            if (rst_i || cls == RSTINI_POWER || cls == RSTINI_BROWN)
                regs_reg[i] <= TABLE[i].init; // RULE11
            else if (cls == RSTINI_EXTPIN || cls == RSTINI_WDOG)
            begin
                if (!TABLE[i].hold)
                    regs_reg[i] <= TABLE[i].init; // RULE5 RULE11
            end
            else if (cls == RSTINI_WAKE_TO || cls == RSTINI_WAKE_IRQ)
                regs_reg[i] <= regs_reg[i]; // RULE6
            else if (wr_commit && idx == i)
                regs_reg[i] <= dat_i[7:0] & TABLE[i].mask; // RULE4
        end
        if (!rst_i)
        begin
            // Condition-dependent time-out and power-down flags.
            case (cls)
                RSTINI_EXTPIN:
                    regs_reg[IX_STATUS] <= {5'h03,
                        regs_reg[IX_STATUS][2:0]}; // RULE7
                RSTINI_WDOG:
                    regs_reg[IX_STATUS] <= {5'h01,
                        regs_reg[IX_STATUS][2:0]}; // RULE7
                RSTINI_WAKE_TO:
                    regs_reg[IX_STATUS] <= {regs_reg[IX_STATUS][7:5], 2'h0,
                        regs_reg[IX_STATUS][2:0]}; // RULE7
                RSTINI_WAKE_IRQ:
                    regs_reg[IX_STATUS] <= {regs_reg[IX_STATUS][7:5], 2'h2,
                        regs_reg[IX_STATUS][2:0]}; // RULE7
                default:
                    ;
            endcase
            // Reset-cause flags: bit 1 on power-on, bit 0 on brown-out.
            if (cls == RSTINI_POWER)
                regs_reg[IX_CAUSE] <= {6'h00, 1'b0,
                    regs_reg[IX_CAUSE][`RI_CAUSE_BRN]}; // RULE9 RULE10
            else if (cls == RSTINI_BROWN)
                regs_reg[IX_CAUSE] <= {6'h00,
                    regs_reg[IX_CAUSE][`RI_CAUSE_POR], 1'b0}; // RULE3
            // Wake source recorded in the flag registers.
            if (cls == RSTINI_WAKE_IRQ)
            begin
                regs_reg[IX_INTCTL] <= regs_reg[IX_INTCTL] |
                    wake_flags_i[7:0]; // RULE2
                regs_reg[IX_FLAGS1] <= regs_reg[IX_FLAGS1] |
                    wake_flags_i[15:8]; // RULE2
                regs_reg[IX_FLAGS2] <= (regs_reg[IX_FLAGS2] |
                    wake_flags_i[23:16]) & TABLE[IX_FLAGS2].mask; // RULE2
            end
            // Forced and condition bits that change even on a wake.
            if (cls != RSTINI_NONE)
                regs_reg[IX_OSC][1:0] <= osc_state_i; // RULE6
            if (cls == RSTINI_WAKE_TO || cls == RSTINI_WAKE_IRQ)
                regs_reg[IX_FVR] <= {regs_reg[IX_FVR][7], 7'h00}; // RULE6
        end
    end

    // Vector load on an interrupt wake while global interrupts are on.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pc_load_o   <= 1'b0;
            pc_vector_o <= '0;
        end
        else
        begin
            pc_load_o <= (cls == RSTINI_WAKE_IRQ) &&
                         regs_reg[IX_INTCTL][`RI_INT_EN_BIT]; // RULE1
            if (cls == RSTINI_WAKE_IRQ && regs_reg[IX_INTCTL][`RI_INT_EN_BIT])
                pc_vector_o <= `RI_IRQ_VECTOR; // RULE1
        end
    end

    // Last applied class, visible to the core.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            reset_class_o <= RSTINI_POWER;
        else if (cls != RSTINI_NONE)
            reset_class_o <= cls;
    end

    // Interrupt status: a new event wins over a clear in the same cycle.
    assign irq_clr = (wr_commit && idx == NREG && !adr_i[11] &&
                      off == `RI_IRQ_CLEAR) ? dat_i[`RI_NEVT-1:0] : '0;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            irq_status_reg <= '0;
        else
            irq_status_reg <= (irq_status_reg & ~irq_clr) |
                              {evt[5], wake_ok, evt[3:2], brown_ok, evt[0]};
    end

    // Interrupt enable and block control registers.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_enable_reg   <= '0;
            ssp_mask_sel_reg <= 1'b0;
        end
        else if (wr_commit && idx == NREG && !adr_i[11])
        begin
            if (off == `RI_IRQ_ENABLE)
                irq_enable_reg <= dat_i[`RI_NEVT-1:0];
            if (off == `RI_BLOCK_CTL)
                ssp_mask_sel_reg <= dat_i[0];
        end
    end

    assign irq_o = |(irq_status_reg & irq_enable_reg);

    // Checks on the reset classes and the bus.
    a_vector_load: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
        (cls == RSTINI_WAKE_IRQ && regs_reg[IX_INTCTL][`RI_INT_EN_BIT])
        |=> pc_load_o && pc_vector_o == 13'h0004)
        else $error("vector not loaded on interrupt wake");
    a_wake_flag_set: assert property (@(posedge clk_i) disable iff (rst_i) // RULE2
        cls == RSTINI_WAKE_IRQ |=> (|{regs_reg[IX_INTCTL],
            regs_reg[IX_FLAGS1], regs_reg[IX_FLAGS2]}))
        else $error("wake without a source flag");
    a_brown_flag_clr: assert property (@(posedge clk_i) disable iff (rst_i) // RULE3
        cls == RSTINI_BROWN |=> !regs_reg[IX_CAUSE][0])
        else $error("brown-out flag not cleared");
    a_brown_flag_hold: assert property (@(posedge clk_i) disable iff (rst_i) // RULE10
        (cls == RSTINI_POWER || cls == RSTINI_EXTPIN) |=>
        $stable(regs_reg[IX_CAUSE][0]))
        else $error("brown-out flag changed by other reset");
    a_unimpl_zero: assert property (@(posedge clk_i) disable iff (rst_i) // RULE4
        (ack_o && !we_i && $past(idx) < NREG) |->
        (dat_o[7:0] & ~TABLE[$past(idx)].mask) == 8'h00 && dat_o[31:8] == '0)
        else $error("unimplemented bit read as one");
    a_other_class_init: assert property (@(posedge clk_i) disable iff (rst_i) // RULE5
        (cls == RSTINI_EXTPIN || cls == RSTINI_WDOG) |=>
        regs_reg[IX_PA_DIR] == 8'hFF)
        else $error("non-power-up values not applied");
    a_wake_keeps: assert property (@(posedge clk_i) disable iff (rst_i) // RULE6
        cls == RSTINI_WAKE_TO |=> $stable(regs_reg[IX_PA_DIR]) &&
        regs_reg[IX_FVR][6:0] == 7'h00)
        else $error("wake altered held contents");
    a_status_flags: assert property (@(posedge clk_i) disable iff (rst_i) // RULE7
        cls == RSTINI_WDOG |=> !regs_reg[IX_STATUS][`RI_STATUS_TMO] &&
        regs_reg[IX_STATUS][`RI_STATUS_PWD])
        else $error("watchdog status flags wrong");
    a_power_wins: assert property (@(posedge clk_i) disable iff (rst_i) // RULE8
        (evt[0] && (evt[2] || evt[3])) |-> cls == RSTINI_POWER ##1
        reset_class_o == RSTINI_POWER)
        else $error("power-on did not take priority");
    a_por_flag_clr: assert property (@(posedge clk_i) disable iff (rst_i) // RULE9
        cls == RSTINI_POWER |=> !regs_reg[IX_CAUSE][1] &&
        regs_reg[IX_STATUS] == 8'h18)
        else $error("power-on values not applied");

    c_wake_vector: cover property (@(posedge clk_i) disable iff (rst_i)
        pc_load_o);
    c_brown_reset: cover property (@(posedge clk_i) disable iff (rst_i)
        cls == RSTINI_BROWN);
    c_pin_reset: cover property (@(posedge clk_i) disable iff (rst_i)
        cls == RSTINI_EXTPIN);
    c_irq_raised: cover property (@(posedge clk_i) disable iff (rst_i)
        irq_o);

endmodule

// file: rstini_core_test.sv
// Self-checking testbench for the reset initialisation register bank.
`timescale 1ns/1ns
module rstini_core_test;
    import rstini_pkg::*;
    logic          clk, rst, cyc, stb, we, ack, pcl, irq;
    logic [11:0]   adr;
    logic [31:0]   wdat, rdat, rd;
    logic [5:0]    src;
    logic [1:0]    cfg, osc;
    logic [3:0]    sel;
    logic [23:0]   wflags;
    logic [12:0]   pcv;
    rstini_class_t cls;
    int            num_errors, num_checks, nload, i;
    logic [9:0]    ti [8] = '{10'h003, 10'h081, 10'h089, 10'h098,
                              10'h189, 10'h18C, 10'h08E, 10'h00C};
    logic [7:0]    tv [8] = '{8'h18, 8'hFF, 8'h0F, 8'h02,
                              8'h07, 8'h02, 8'h00, 8'h00};

    // Source bits: power, brown, pin, watchdog, wake irq, wake timeout.
    rstini_core u_dut (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat),
        .ack_o(ack), .power_on_i(src[0]), .brownout_i(src[1]),
        .ext_reset_pin_i(src[2]), .watchdog_i(src[3]),
        .wake_irq_i(src[4]), .wake_timeout_i(src[5]),
        .brownout_detect_config_i(cfg), .wake_flags_i(wflags),
        .osc_state_i(osc), .pc_load_o(pcl), .pc_vector_o(pcv),
        .reset_class_o(cls), .irq_o(irq));

    // Free-running 100 MHz core clock.
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input string nm, input logic [31:0] s, e);
        num_checks++;
        if (s !== e)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask

    // One classic cycle; the master waits for ack as long as it takes, only
    // the watchdog ends a hung wait, and an ack latency of two clock edges is then checked.
    task automatic wb(input logic w, input logic [9:0] ix, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        sel  <= 4'h1;
        adr  <= {ix, 2'b00};
        wdat <= {24'h0, d};
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        sel <= 4'h0;
        check("wishbone ack latency", n, 2);
    endtask

    task automatic rc(input logic [9:0] ix, input logic [7:0] e);
        wb(1'b0, ix, 8'h00);
        check($sformatf("reg %h", ix), rd, {24'h0, e});
    endtask

    // Sources are held long enough to pass the input synchroniser filter.
    task automatic ev(input logic [5:0] m);
        @(posedge clk);
        src <= m;
        repeat (8)
        begin
            @(posedge clk);
            if (pcl === 1'b1)
                nload++;
        end
        src <= 6'h00;
        repeat (4) @(posedge clk);
    endtask

    task automatic test_done;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Watchdog well beyond the few hundred cycles the sequence needs.
    initial
    begin
        repeat (20000) @(posedge clk);
        num_errors++;
        test_done;
    end

    // Main sequence.
    initial
    begin
        {rst, cyc, stb, we, sel, adr, wdat, src, wflags, osc} = '0;
        rst = 1'b1;
        cfg = 2'h1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        check("class", 32'(cls), 32'(RSTINI_POWER));
        check("pc vector", {19'h0, pcv}, 32'h0);
        for (i = 0; i < 8; i++)
            rc(ti[i], tv[i]);
        wb(1'b1, 10'h089, 8'hFF);
        rc(10'h089, 8'h0F);
        wb(1'b1, 10'h09F, 8'hFF);
        rc(10'h09F, 8'h1F);
        wb(1'b1, 10'h113, 8'hFF);
        rc(10'h113, 8'hEC);
        wb(1'b1, 10'h08E, 8'h03);
        wb(1'b1, 10'h085, 8'h00);
        wb(1'b1, 10'h09A, 8'h5A);
        wb(1'b1, 10'h003, 8'h07);
        ev(6'h04);
        check("class", 32'(cls), 32'(RSTINI_EXTPIN));
        rc(10'h085, 8'hFF);
        rc(10'h09A, 8'h5A);
        rc(10'h003, 8'h1F);
        rc(10'h08E, 8'h03);
        ev(6'h08);
        check("class", 32'(cls), 32'(RSTINI_WDOG));
        rc(10'h003, 8'h0F);
        wb(1'b1, 10'h085, 8'h00);
        osc <= 2'h3;
        ev(6'h20);
        rc(10'h085, 8'h00);
        rc(10'h090, 8'h23);
        rc(10'h003, 8'h07);
        wb(1'b1, 10'h00B, 8'h80);
        wflags <= 24'h000100;
        nload = 0;
        ev(6'h10);
        check("pc loads", nload, 1);
        check("pc vector", {19'h0, pcv}, 32'h4);
        rc(10'h00C, 8'h01);
        rc(10'h003, 8'h17);
        wflags <= 24'h0;
        cfg <= 2'h0;
        ev(6'h02);
        rc(10'h08E, 8'h03);
        cfg <= 2'h1;
        ev(6'h02);
        rc(10'h08E, 8'h02);
        rc(10'h085, 8'hFF);
        wb(1'b1, 10'h08E, 8'h03);
        ev(6'h05);
        check("class", 32'(cls), 32'(RSTINI_POWER));
        rc(10'h08E, 8'h01);
        rc(10'h003, 8'h18);
        // Interrupt: clear, enable only the pin event, raise it, mask it.
        wb(1'b1, 10'h1F2, 8'h3F);
        rc(10'h1F0, 8'h00);
        wb(1'b1, 10'h1F1, 8'h04);
        check("irq", {31'h0, irq}, 32'h0);
        ev(6'h04);
        check("irq", {31'h0, irq}, 32'h1);
        rc(10'h1F0, 8'h04);
        wb(1'b1, 10'h1F1, 8'h00);
        @(posedge clk);
        check("irq", {31'h0, irq}, 32'h0);
        rc(10'h1F2, 8'h00);
        // The block control bit steers the shared serial offset to the mask.
        wb(1'b1, 10'h1F3, 8'h01);
        rc(10'h1F3, 8'h01);
        rc(10'h093, 8'hFF);
        wb(1'b1, 10'h1F3, 8'h00);
        rc(10'h093, 8'h00);
        rc(10'h200, 8'h00);
        test_done;
    end
endmodule
